// ---- design/pl_cfg.svh ----
// Timing constants of the pulse link and state timers
`ifndef PL_CFG_SVH
`define PL_CFG_SVH
`define PL_CLK_MHZ 125
`define PL_CYC_CEIL(ns) ((((ns) * `PL_CLK_MHZ) + 999) / 1000)
`define PL_CYC_FLOOR(ns) (((ns) * `PL_CLK_MHZ) / 1000)
`define PL_CYC_PER_S (`PL_CLK_MHZ * 1000000)
`define PL_T_SLEEP_S 2
`define PL_T_REFUP_US 3500
`define PL_T_READY_NS 10000
`define PL_T_DATA_DLY_NS 265
`define PL_T_HPW_CS_NS 150
`define PL_T_HPW_D_NS 50
`define PL_T_GOV5_NS 670
`define PL_T_GOV6_NS 860
`define PL_T_BLOCK_NS 2000
`define PL_SYNC_LAT 3
`define PL_FLAG_LAT 1
`define PL_DTO_BASE 4'h0
`define PL_TMR_W 32
`endif

// ---- design/pl_pkg.sv ----
// Types of the pulse link block
package pl_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_HALF1, TX_HALF2} pl_tx_st_t;

  typedef struct packed {
    logic sel_s1;
    logic sel_s2;
    logic sel_d;
    logic sck_s1;
    logic sck_s2;
    logic sck_d;
    logic sdi_s1;
    logic sdi_s2;
    logic wake_s1;
    logic wake_s2;
    logic wake_d;
    pl_tx_st_t st;
    logic [4:0] half;
    logic is_long;
    logic pos;
    logic [5:0] dly;
    logic dpend;
    logic dbit;
    logic cpend;
    logic clvl;
    logic [6:0] gov;
    logic txp;
    logic txm;
    logic ready;
    logic timeout;
    logic conv_go;
    logic blocked;
  } pl_state_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic done;
  } pl_tmr_state_t;
endpackage

// ---- design/pl_tmr_if.sv ----
// Start and expiry signals between the block and one timer
`timescale 1ns/100ps
interface pl_tmr_if;
  logic start;
  logic [31:0] len;
  logic busy;
  logic done;
  modport ctl (output start, output len, input busy, input done);
  modport tmr (input start, input len, output busy, output done);
endinterface

// ---- design/pl_timer.sv ----
// Down-counting timer with one-cycle expiry pulse
`timescale 1ns/100ps
`include "pl_cfg.svh"
module pl_timer (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  pl_tmr_if.tmr t
);
  pl_pkg::pl_tmr_state_t r_r;
  pl_pkg::pl_tmr_state_t r_nxt;

  always_comb begin
    r_nxt = r_r;
    r_nxt.done = 1'b0;
    if (t.start) begin
      r_nxt.cnt = t.len;
    end else if (r_r.cnt != 32'h0) begin
      r_nxt.cnt = r_r.cnt - 32'h1;
      r_nxt.done = (r_r.cnt == 32'h1);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign t.busy = (r_r.cnt != 32'h0);
  assign t.done = r_r.done;
endmodule

// ---- design/pl_link.sv ----
// Pulse link transmitter with governors and state timers
`timescale 1ns/100ps
`include "pl_cfg.svh"
// How it works
// RULE1 - Watchdog timer expires after two seconds when timeout field is zero.
// RULE2 - Start from standby waits 3.5 ms for the reference; otherwise none.
// RULE3 - Wake on the link leads to ready within 10 microseconds.
// RULE4 - Short data pulse follows each clock rise by about 265 ns.
// RULE5 - Each select transition sends a long pulse within 100 ns.
// RULE6 - Release long pulse to next assert long pulse spaced 0.67 us.
// RULE7 - Last data pulse to next select long pulse spaced 0.86 us.
// RULE8 - Direction reversal blocks port activity for 2 to 10 us.
// RULE9 - Host keeps select released at least 2 us between transactions.
// RULE10 - Long pulses mark select edges; short pulses carry data by polarity.
module pl_link #(
  parameter int unsigned P_SLEEP_CYC = `PL_T_SLEEP_S * `PL_CYC_PER_S,
  parameter int unsigned P_REFUP_CYC = `PL_T_REFUP_US * `PL_CLK_MHZ
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_port_select_n,
  input wire logic i_sck,
  input wire logic i_sdi,
  input wire logic i_wake,
  input wire logic i_dir_rev,
  input wire logic i_conv_req,
  input wire logic i_standby,
  input wire logic i_wdt_kick,
  input wire logic [3:0] i_discharge_timeout_field,
  output logic o_link_pos,
  output logic o_link_neg,
  output logic o_ready,
  output logic o_timeout,
  output logic o_conv_go,
  output logic o_blocked
);
  localparam logic [5:0] DATA_DLY =
    6'(`PL_CYC_FLOOR(`PL_T_DATA_DLY_NS) - `PL_SYNC_LAT);
  localparam logic [4:0] HPW_CS = 5'(`PL_CYC_FLOOR(`PL_T_HPW_CS_NS));
  localparam logic [4:0] HPW_D = 5'(`PL_CYC_FLOOR(`PL_T_HPW_D_NS));
  localparam logic [6:0] GOV5 = 7'(`PL_CYC_CEIL(`PL_T_GOV5_NS));
  localparam logic [6:0] GOV6 = 7'(`PL_CYC_CEIL(`PL_T_GOV6_NS));
  // Counted from the wake pin, so sync and flag stages come off the top
  localparam logic [31:0] READY_CYC =
    32'(`PL_CYC_FLOOR(`PL_T_READY_NS) - `PL_SYNC_LAT - `PL_FLAG_LAT);
  localparam logic [31:0] BLOCK_CYC = 32'(`PL_CYC_CEIL(`PL_T_BLOCK_NS));

  pl_pkg::pl_state_t s_r;
  pl_pkg::pl_state_t s_nxt;
  logic sel_edge;
  logic sck_rise;
  logic wake_rise;
  logic act;

  pl_tmr_if t_sleep ();
  pl_tmr_if t_refup ();
  pl_tmr_if t_ready ();
  pl_tmr_if t_block ();

  pl_timer u_sleep (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .t(t_sleep));
  pl_timer u_refup (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .t(t_refup));
  pl_timer u_ready (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .t(t_ready));
  pl_timer u_block (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .t(t_block));

  assign sel_edge = s_r.sel_s2 ^ s_r.sel_d;
  assign sck_rise = s_r.sck_s2 & ~s_r.sck_d & ~s_r.sel_s2;
  assign wake_rise = s_r.wake_s2 & ~s_r.wake_d;
  // Link events are ignored while asleep or inside the reversal window
  assign act = s_r.ready & ~t_block.busy; // RULE8

  always_comb begin
    s_nxt = s_r;
    s_nxt.timeout = 1'b0;
    s_nxt.conv_go = 1'b0;
    t_sleep.start = 1'b0;
    t_refup.start = 1'b0;
    t_ready.start = 1'b0;
    t_block.start = 1'b0;
    // Only codes other than zero stretch the period; zero is the base
    if (i_discharge_timeout_field == `PL_DTO_BASE) begin
      t_sleep.len = P_SLEEP_CYC; // RULE1
    end else begin
      t_sleep.len = P_SLEEP_CYC * (32'(i_discharge_timeout_field) + 32'h1);
    end
    t_refup.len = P_REFUP_CYC;
    t_ready.len = READY_CYC;
    t_block.len = BLOCK_CYC;

    // Select, clock, data and wake pins pass two flops before any logic looks at them
    s_nxt.sel_s1 = i_port_select_n;
    s_nxt.sel_s2 = s_r.sel_s1;
    s_nxt.sel_d = s_r.sel_s2;
    s_nxt.sck_s1 = i_sck;
    s_nxt.sck_s2 = s_r.sck_s1;
    s_nxt.sck_d = s_r.sck_s2;
    s_nxt.sdi_s1 = i_sdi;
    s_nxt.sdi_s2 = s_r.sdi_s1;
    s_nxt.wake_s1 = i_wake;
    s_nxt.wake_s2 = s_r.wake_s1;
    s_nxt.wake_d = s_r.wake_s2;

    if (s_r.gov != 7'h0) begin
      s_nxt.gov = s_r.gov - 7'h1;
    end
    if (s_r.dpend && s_r.dly != 6'h0) begin
      s_nxt.dly = s_r.dly - 6'h1;
    end

    case (s_r.st)
      pl_pkg::TX_IDLE: begin
        // Data first: a select pulse must trail the last data pulse
        if (s_r.dpend && s_r.dly == 6'h0) begin
          s_nxt.is_long = 1'b0; // RULE10
          s_nxt.pos = s_r.dbit; // RULE4
          s_nxt.dpend = 1'b0;
          s_nxt.half = HPW_D;
          s_nxt.st = pl_pkg::TX_HALF1;
        end else if (s_r.cpend && s_r.gov == 7'h0) begin
          s_nxt.is_long = 1'b1; // RULE10
          s_nxt.pos = s_r.clvl; // RULE5
          s_nxt.cpend = 1'b0;
          s_nxt.half = HPW_CS;
          s_nxt.st = pl_pkg::TX_HALF1;
        end
      end
      pl_pkg::TX_HALF1: begin
        s_nxt.half = s_r.half - 5'h1;
        if (s_r.half == 5'h1) begin
          s_nxt.half = s_r.is_long ? HPW_CS : HPW_D;
          s_nxt.st = pl_pkg::TX_HALF2;
        end
      end
      pl_pkg::TX_HALF2: begin
        s_nxt.half = s_r.half - 5'h1;
        if (s_r.half == 5'h1) begin
          s_nxt.st = pl_pkg::TX_IDLE;
          if (!s_r.is_long) begin
            s_nxt.gov = GOV6; // RULE7
          end else if (s_r.pos) begin
            s_nxt.gov = GOV5; // RULE6
          end
        end
      end
      default: begin
        s_nxt.st = pl_pkg::TX_IDLE;
      end
    endcase

    // Events after the transmitter so a new one is never lost
    if (sel_edge && act) begin
      s_nxt.cpend = 1'b1; // RULE5
      s_nxt.clvl = s_r.sel_s2;
      t_sleep.start = 1'b1;
    end
    if (sck_rise && act) begin
      s_nxt.dpend = 1'b1; // RULE4
      s_nxt.dbit = s_r.sdi_s2;
      s_nxt.dly = DATA_DLY;
    end

    if (wake_rise && !s_r.ready && !t_ready.busy) begin
      t_ready.start = 1'b1; // RULE3
    end
    if (t_ready.done) begin
      s_nxt.ready = 1'b1; // RULE3
      t_sleep.start = 1'b1;
    end
    if (i_wdt_kick) begin
      t_sleep.start = 1'b1;
    end
    if (t_sleep.done && !t_sleep.start) begin
      s_nxt.ready = 1'b0; // RULE1
      s_nxt.timeout = 1'b1;
    end

    if (i_dir_rev) begin
      t_block.start = 1'b1; // RULE8
    end
    s_nxt.blocked = t_block.busy | t_block.start;

    if (i_conv_req) begin
      if (i_standby) begin
        t_refup.start = 1'b1; // RULE2
      end else begin
        s_nxt.conv_go = 1'b1; // RULE2
      end
    end
    if (t_refup.done) begin
      s_nxt.conv_go = 1'b1;
    end

    // First half carries the polarity, second half its inverse
    s_nxt.txp = 1'b0;
    s_nxt.txm = 1'b0;
    if (s_nxt.st == pl_pkg::TX_HALF1) begin
      s_nxt.txp = s_nxt.pos;
      s_nxt.txm = ~s_nxt.pos;
    end else if (s_nxt.st == pl_pkg::TX_HALF2) begin
      s_nxt.txp = ~s_nxt.pos;
      s_nxt.txm = s_nxt.pos;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_r <= '0;
      s_r.sel_s1 <= 1'b1;
      s_r.sel_s2 <= 1'b1;
      s_r.sel_d <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_link_pos = s_r.txp;
  assign o_link_neg = s_r.txm;
  assign o_ready = s_r.ready;
  assign o_timeout = s_r.timeout;
  assign o_conv_go = s_r.conv_go;
  assign o_blocked = s_r.blocked;
endmodule

// ---- sim/pl_link_checker.sv ----
// Port assertions for the pulse link block
`timescale 1ns/100ps
module pl_link_checker (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_wake,
  input wire logic i_dir_rev,
  input wire logic i_conv_req,
  input wire logic i_standby,
  input wire logic o_link_pos,
  input wire logic o_link_neg,
  input wire logic o_ready,
  input wire logic o_timeout,
  input wire logic o_conv_go,
  input wire logic o_blocked
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  a_pol_excl: assert property (
    !(o_link_pos && o_link_neg)) else $error("both halves high");
  // Half is 6 cycles for data or 18 for select
  a_half_len: assert property (
    $rose(o_link_pos) |-> o_link_pos[*6] ##1
    (!o_link_pos or ##12 !o_link_pos)) else $error("bad half width");
  a_conv_now: assert property (
    i_conv_req && !i_standby |=> o_conv_go) else $error("go late");
  a_conv_settle: assert property (
    i_conv_req && i_standby |-> ##102 o_conv_go) else $error("no settle");
  a_block_start: assert property (
    i_dir_rev |=> o_blocked) else $error("block not started");
  a_block_len: assert property (
    $rose(o_blocked) |-> ##250 o_blocked ##[1:1000] !o_blocked)
    else $error("block window length");
  // Cycles since the wake pin rose; 10 us is 1250 cycles
  localparam logic [10:0] READY_MAX = 11'h4e2;
  logic wake_q;
  logic wake_arm;
  logic [10:0] wake_cnt;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wake_q <= 1'h0;
      wake_arm <= 1'h0;
      wake_cnt <= 11'h0;
    end else begin
      wake_q <= i_wake;
      if (o_ready) begin
        wake_arm <= 1'h0;
        wake_cnt <= 11'h0;
      end else if (i_wake && !wake_q) begin
        wake_arm <= 1'h1;
        wake_cnt <= 11'h1;
      end else if (wake_arm && wake_cnt != 11'h7ff) begin
        wake_cnt <= wake_cnt + 11'h1;
      end
    end
  end
  a_ready_wake: assert property (
    wake_cnt <= READY_MAX) else $error("ready late");
  a_timeout_drop: assert property (
    o_timeout |-> !o_ready && $past(o_ready)) else $error("expiry");
endmodule
bind pl_link pl_link_checker u_chk (.i_clk_sys, .i_reset_n, .i_wake,
  .i_dir_rev, .i_conv_req, .i_standby, .o_link_pos, .o_link_neg,
  .o_ready, .o_timeout, .o_conv_go, .o_blocked);

// ---- sim/pl_host_model.sv ----
// Host model driving select, serial clock and data pins
`timescale 1ns/100ps
module pl_host_model (
  input wire logic i_clk_sys,
  output logic o_sel_n,
  output logic o_sck,
  output logic o_sdi
);
  initial begin
    o_sel_n = 1'h1;
    o_sck = 1'h0;
    o_sdi = 1'h0;
  end
  int rel_age = 0;
  always @(posedge i_clk_sys) rel_age <= o_sel_n ? rel_age + 1 : 0;
  // Asserts wait out 2 us of release unless a test asks for early
  task automatic sel(input logic lvl_n, input int w, input logic early);
    int k = 0;
    repeat (w) @(posedge i_clk_sys);
    while (!lvl_n && !early && rel_age < 250 && k < 300) begin
      @(posedge i_clk_sys);
      k++;
    end
    o_sel_n <= lvl_n;
  endtask
  // One 65-cycle beat; data inverted once hold time is over
  task automatic beat(input logic b);
    @(posedge i_clk_sys);
    o_sdi <= b;
    repeat (32) @(posedge i_clk_sys);
    o_sck <= 1'h1;
    repeat (32) @(posedge i_clk_sys);
    o_sck <= 1'h0;
    o_sdi <= ~b;
  endtask
endmodule

// ---- sim/pl_link_tb_top.sv ----
// Testbench for the pulse link block
`timescale 1ns/100ps
module pl_link_tb_top;
  logic i_clk_sys, i_reset_n, i_wake, i_dir_rev, i_conv_req, i_standby;
  logic i_wdt_kick, sel_n, sck, sdi, pos, neg, rdy, tmo, go, blk;
  logic [3:0] dtf;
  int err_total = 0;
  int checks_done = 0;
  int idle = 0;
  pl_host_model host (.i_clk_sys, .o_sel_n(sel_n), .o_sck(sck),
    .o_sdi(sdi));
  // Short counts keep the run brief
  pl_link #(.P_SLEEP_CYC(200), .P_REFUP_CYC(100)) dut (.i_clk_sys,
    .i_reset_n, .i_port_select_n(sel_n), .i_sck(sck), .i_sdi(sdi),
    .i_wake, .i_dir_rev, .i_conv_req, .i_standby, .i_wdt_kick,
    .i_discharge_timeout_field(dtf), .o_link_pos(pos),
    .o_link_neg(neg), .o_ready(rdy), .o_timeout(tmo), .o_conv_go(go),
    .o_blocked(blk));
  initial begin
    i_clk_sys = 1'h0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) idle <= (pos || neg) ? 0 : idle + 1;
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'h1) begin
      err_total++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic step(inout int n);
    @(posedge i_clk_sys);
    #1;
    n++;
    if (n > 3000) begin
      check(1'h0, "wait ran out");
      summarize;
    end
  endtask
  task automatic wait_pulse(output int n, output logic p);
    n = 0;
    while (pos || neg) step(n);
    while (!(pos || neg)) step(n);
    p = pos;
  endtask
  task automatic t_conv(input logic sb, input int exp);
    int n = 0;
    @(posedge i_clk_sys);
    i_standby <= sb;
    i_conv_req <= 1'h1;
    @(posedge i_clk_sys);
    i_conv_req <= 1'h0;
    #1;
    while (!go) step(n);
    check(n == exp, "conversion start delay");
    $display("conv test done");
  endtask
  task automatic t_block;
    int n = 0;
    @(posedge i_clk_sys);
    i_dir_rev <= 1'h1;
    @(posedge i_clk_sys);
    i_dir_rev <= 1'h0;
    #1;
    while (!blk) step(n);
    n = 0;
    while (blk) step(n);
    check(n >= 250 && n <= 1250, "block window length");
    $display("block test done");
  endtask
  task automatic t_wake;
    int n = 0;
    @(posedge i_clk_sys);
    i_wake <= 1'h0;
    @(posedge i_clk_sys);
    i_wake <= 1'h1;
    #1;
    check(rdy === 1'h0, "ready before wake");
    while (!rdy) step(n);
    check(n <= 1250, "ready too late");
    $display("wake test done");
  endtask
  // Governor gaps: data then release, release then early assert
  task automatic t_link;
    int n;
    logic p;
    host.sel(1'h0, 8, 1'h0);
    wait_pulse(n, p);
    check(n <= 12 && p === 1'h0, "assert pulse");
    fork host.beat(1'h1); wait_pulse(n, p); join
    check(n >= 62 && n <= 70 && p === 1'h1, "data one");
    fork host.beat(1'h0); wait_pulse(n, p); join
    check(n >= 62 && n <= 70 && p === 1'h0, "data zero");
    host.sel(1'h1, 1, 1'h0);
    wait_pulse(n, p);
    check(idle >= 87 && idle <= 137 && p === 1'h1, "data gap");
    // Early assert cuts the host's release time short to reach the governor
    host.sel(1'h0, 1, 1'h1);
    wait_pulse(n, p);
    check(idle >= 68 && idle <= 106 && p === 1'h0, "cs gap");
    $display("link test done");
  endtask
  task automatic t_dog(input logic [3:0] f, input int lo, input int hi);
    int n = 0;
    @(posedge i_clk_sys);
    dtf <= f;
    i_wdt_kick <= 1'h1;
    @(posedge i_clk_sys);
    i_wdt_kick <= 1'h0;
    #1;
    while (!tmo) step(n);
    check(n >= lo && n <= hi && rdy === 1'h0, "expiry");
    $display("watchdog test done");
  endtask
  initial begin
    i_reset_n = 1'h0;
    {i_wake, i_dir_rev, i_conv_req, i_standby, i_wdt_kick} = 5'h00;
    dtf = 4'h0;
    repeat (6) @(posedge i_clk_sys);
    i_reset_n <= 1'h1;
    t_conv(1'h1, 101);
    t_conv(1'h0, 0);
    t_block;
    t_wake;
    t_link;
    t_dog(4'h0, 180, 220);
    // Code one doubles the period
    t_wake;
    t_dog(4'h1, 360, 440);
    summarize;
  end
endmodule
